// [dead_time_unit.sv]
// Complementary output dead-time insertion for one generator
module dead_time_unit
  import pwm_dt_pkg::*;
#(
  parameter int DT_W = 14
)
(
  input  wire logic            sys_clk,
  input  wire logic            nrst,
  input  wire logic            pwm_tick,
  input  wire logic            raw_pwm,
  input  wire logic [DT_W-1:0] dead_time_value,
  input  wire logic [DT_W-1:0] alternate_dead_time_value,
  output logic                 pwm_high_output,
  output logic                 pwm_low_output
);
  typedef struct packed
  {
    dt_state_t       st;
    logic [DT_W-1:0] cnt;
    logic            high;
    logic            low;
  } dtu_state_t;

  dtu_state_t s_ff;
  dtu_state_t nxt_s;

  // Turn-on delayed by the programmed count plus one PWM clock periods
  always_comb
  begin
    nxt_s = s_ff;
    case (s_ff.st)
      DT_BOTH_OFF:
      begin
        if (pwm_tick)
        begin
          if (s_ff.cnt != '0)
            nxt_s.cnt = s_ff.cnt - 1'b1;
          else if (raw_pwm)
          begin
            nxt_s.st   = DT_HIGH_ON;
            nxt_s.high = 1'b1;
          end
          else
          begin
            nxt_s.st  = DT_LOW_ON;
            nxt_s.low = 1'b1;
          end
        end
      end
      DT_HIGH_ON:
      begin
        if (!raw_pwm)
        begin
          nxt_s.st   = DT_BOTH_OFF;
          nxt_s.high = 1'b0;
          nxt_s.cnt  = alternate_dead_time_value;
        end
      end
      DT_LOW_ON:
      begin
        if (raw_pwm)
        begin
          nxt_s.st  = DT_BOTH_OFF;
          nxt_s.low = 1'b0;
          nxt_s.cnt = dead_time_value;
        end
      end
      default:
      begin
        nxt_s.st = DT_BOTH_OFF;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      s_ff <= '{st: DT_BOTH_OFF, cnt: '0, high: 1'b0, low: 1'b0};
    else
      s_ff <= nxt_s;
  end

  assign pwm_high_output = s_ff.high;
  assign pwm_low_output  = s_ff.low;
endmodule // dead_time_unit

// [edge_blanker.sv]
// Leading-edge and state blanking of fault and current-limit inputs for one generator
`include "pwm_dt_params.svh"

module edge_blanker
  import pwm_dt_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      nrst,
  input  wire logic      pwm_high_output,
  input  wire logic      pwm_low_output,
  input  wire logic      state_blank_sig,
  input  wire reg_word_t edge_blanking_control,
  input  wire reg_word_t blank_length,
  input  wire logic      fault_in,
  input  wire logic      clim_in,
  output logic           fault_out,
  output logic           clim_out,
  output logic           blank_active
);
  typedef struct packed
  {
    logic      hi_d;
    logic      lo_d;
    reg_word_t cnt;
    logic      fault;
    logic      clim;
  } blk_state_t;

  blk_state_t s_ff;
  blk_state_t nxt_s;
  logic       trig;
  logic       state_blank;
  logic       leb_on;

  // Edge triggers, state blanking and masked outputs
  always_comb
  begin
    nxt_s = s_ff;
    trig = (edge_blanking_control[`BIT_HIGH_RISE] && pwm_high_output && !s_ff.hi_d)
        || (edge_blanking_control[`BIT_HIGH_FALL] && !pwm_high_output && s_ff.hi_d)
        || (edge_blanking_control[`BIT_LOW_RISE] && pwm_low_output && !s_ff.lo_d)
        || (edge_blanking_control[`BIT_LOW_FALL] && !pwm_low_output && s_ff.lo_d);
    state_blank = (edge_blanking_control[`BIT_SIG_HIGH] && state_blank_sig)
               || (edge_blanking_control[`BIT_SIG_LOW] && !state_blank_sig)
               || (edge_blanking_control[`BIT_HIGH_OUT_HIGH] && pwm_high_output)
               || (edge_blanking_control[`BIT_HIGH_OUT_LOW] && !pwm_high_output)
               || (edge_blanking_control[`BIT_LOW_OUT_HIGH] && pwm_low_output)
               || (edge_blanking_control[`BIT_LOW_OUT_LOW] && !pwm_low_output);
    leb_on = s_ff.cnt != '0;
    nxt_s.hi_d = pwm_high_output;
    nxt_s.lo_d = pwm_low_output;
    if (trig)
      nxt_s.cnt = blank_length;
    else if (leb_on)
      nxt_s.cnt = s_ff.cnt - 16'h0001;
    nxt_s.fault = fault_in && !((edge_blanking_control[`BIT_FAULT_BLANK] && leb_on) || state_blank);
    nxt_s.clim  = clim_in && !((edge_blanking_control[`BIT_CLIM_BLANK] && leb_on) || state_blank);
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      s_ff <= '{hi_d: 1'b0, lo_d: 1'b0, cnt: 16'h0000, fault: 1'b0, clim: 1'b0};
    else
      s_ff <= nxt_s;
  end

  assign fault_out    = s_ff.fault;
  assign clim_out     = s_ff.clim;
  assign blank_active = leb_on;
endmodule // edge_blanker

// [pwm_dt_blank_cfg.sv]
// Register file, dead-time units and blankers for all PWM generators
`include "pwm_dt_params.svh"

// Behaviour
// - Five generators, each with own registers
// - Primary dead time is 14 bits
// - Alternate dead time is 14 bits
// - Dead-time bits 15:14 read zero
// - Trigger, fault, current-limit bits placed correctly
// - State blank signal masks fault inputs
module pwm_dt_blank_cfg
  import pwm_dt_pkg::*;
#(
  parameter int N = `PWM_GEN_COUNT
)
(
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  input  wire pwm_dt_pkg::reg_addr_t reg_addr,
  input  wire pwm_dt_pkg::reg_word_t reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output pwm_dt_pkg::reg_word_t      reg_rdata,
  input  wire logic                  pwm_tick,
  input  wire logic [N-1:0]          raw_pwm,
  input  wire logic [N-1:0]          state_blank_sig,
  input  wire logic [N-1:0]          fault_in,
  input  wire logic [N-1:0]          clim_in,
  output logic [N-1:0]               pwm_high_output,
  output logic [N-1:0]               pwm_low_output,
  output logic [N-1:0]               fault_out,
  output logic [N-1:0]               clim_out,
  output logic [N-1:0]               blank_active
);
  import pwm_dt_pkg::*;

  typedef struct packed
  {
    reg_word_t [N-1:0] dt;
    reg_word_t [N-1:0] alt;
    reg_word_t [N-1:0] blk;
    reg_word_t [N-1:0] len;
    reg_word_t         rdata;
    logic [N-1:0]      sbs_m;
    logic [N-1:0]      sbs;
    logic [N-1:0]      flt_m;
    logic [N-1:0]      flt;
    logic [N-1:0]      cl_m;
    logic [N-1:0]      cl;
  } cfg_state_t;

  cfg_state_t s_ff;
  cfg_state_t nxt_s;
  logic [7:0] gen_idx;
  logic [7:0] reg_sel;
  logic       gen_ok;

  // Address split: generator block of four words, then register in block
  assign gen_idx = reg_addr / `REG_STRIDE;
  assign reg_sel = reg_addr % `REG_STRIDE;
  assign gen_ok  = gen_idx < 8'(N);

  // Register writes, read mux, and input synchronisers
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.sbs_m = state_blank_sig;
    nxt_s.sbs   = s_ff.sbs_m;
    nxt_s.flt_m = fault_in;
    nxt_s.flt   = s_ff.flt_m;
    nxt_s.cl_m  = clim_in;
    nxt_s.cl    = s_ff.cl_m;
    nxt_s.rdata = `REG_RESET;
    if (reg_wr && gen_ok)
    begin
      if (reg_sel == `OFS_DEAD_TIME)
        nxt_s.dt[gen_idx] = reg_wdata & `DT_MASK;
      else if (reg_sel == `OFS_ALT_DEAD_TIME)
        nxt_s.alt[gen_idx] = reg_wdata & `DT_MASK;
      else if (reg_sel == `OFS_BLANK_CTRL)
        nxt_s.blk[gen_idx] = reg_wdata & `BLANK_CTRL_MASK;
      else if (reg_sel == `OFS_BLANK_COUNT)
        nxt_s.len[gen_idx] = reg_wdata;
    end
    if (reg_rd && gen_ok)
    begin
      if (reg_sel == `OFS_DEAD_TIME)
        nxt_s.rdata = s_ff.dt[gen_idx];
      else if (reg_sel == `OFS_ALT_DEAD_TIME)
        nxt_s.rdata = s_ff.alt[gen_idx];
      else if (reg_sel == `OFS_BLANK_CTRL)
        nxt_s.rdata = s_ff.blk[gen_idx];
      else if (reg_sel == `OFS_BLANK_COUNT)
        nxt_s.rdata = s_ff.len[gen_idx];
    end
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      s_ff     <= '0;
      s_ff.len <= {N{`BLANK_LEN_RESET}};
    end
    else
      s_ff <= nxt_s;
  end

  assign reg_rdata = s_ff.rdata;

  // One dead-time unit and one blanker per generator
  for (genvar g = 0; g < N; g++)
  begin : gen_ch
    dead_time_unit #(.DT_W(`DT_W)) u_dt
    (
      .sys_clk                   (sys_clk),
      .nrst                      (nrst),
      .pwm_tick                  (pwm_tick),
      .raw_pwm                   (raw_pwm[g]),
      .dead_time_value           (s_ff.dt[g][`DT_W-1:0]),
      .alternate_dead_time_value (s_ff.alt[g][`DT_W-1:0]),
      .pwm_high_output           (pwm_high_output[g]),
      .pwm_low_output            (pwm_low_output[g])
    );

    edge_blanker u_blk
    (
      .sys_clk               (sys_clk),
      .nrst                  (nrst),
      .pwm_high_output       (pwm_high_output[g]),
      .pwm_low_output        (pwm_low_output[g]),
      .state_blank_sig       (s_ff.sbs[g]),
      .edge_blanking_control (s_ff.blk[g]),
      .blank_length          (s_ff.len[g]),
      .fault_in              (s_ff.flt[g]),
      .clim_in               (s_ff.cl[g]),
      .fault_out             (fault_out[g]),
      .clim_out              (clim_out[g]),
      .blank_active          (blank_active[g])
    );
  end
endmodule // pwm_dt_blank_cfg

// [pwm_dt_blank_cfg_bench.sv]
// Self-checking bench for the dead-time and blanking block
module pwm_dt_blank_cfg_bench
  import pwm_dt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic      sys_clk, nrst, reg_wr, reg_rd, pwm_tick;
  reg_addr_t reg_addr;
  reg_word_t reg_wdata, reg_rdata;
  logic [4:0] raw_pwm, sblank, fault_in, clim_in, hi, lo, f_out, c_out, blank;
  int        failures, n_compared;

  pwm_dt_blank_cfg i_dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_tick(pwm_tick), .raw_pwm(raw_pwm),
    .state_blank_sig(sblank), .fault_in(fault_in), .clim_in(clim_in), .pwm_high_output(hi),
    .pwm_low_output(lo), .fault_out(f_out), .clim_out(c_out), .blank_active(blank));

  function automatic reg_addr_t ad(int g, int o);
    return reg_addr_t'(g * 4 + o);
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(reg_addr_t a, reg_word_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(reg_addr_t a, reg_word_t e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask

  task automatic t_reset;
    for (int g = 0; g < 5; g++)
    begin
      rd(ad(g, 0), 16'h0000);
      rd(ad(g, 1), 16'h0000);
      rd(ad(g, 2), 16'h0000);
      rd(ad(g, 3), 16'h0008);
    end
    $display("reset values done");
  endtask

  task automatic t_regs;
    for (int g = 0; g < 5; g++)
    begin
      wr(ad(g, 0), 16'hFFF0 + 16'(g));
      wr(ad(g, 1), 16'hC000 + 16'(g));
      wr(ad(g, 2), 16'hFFFF);
      wr(ad(g, 3), 16'h0100 + 16'(g));
    end
    for (int g = 0; g < 5; g++)
    begin
      rd(ad(g, 0), 16'h3FF0 + 16'(g));
      rd(ad(g, 1), 16'h0000 + 16'(g));
      rd(ad(g, 2), 16'hFC3F);
      rd(ad(g, 3), 16'h0100 + 16'(g));
    end
    wr(8'h14, 16'hFFFF);
    rd(8'h14, 16'h0000);
    rd(8'hFF, 16'h0000);
    rd(ad(0, 0), 16'h3FF0);
    $display("register access done");
  endtask

  task automatic t_dt;
    int n;
    wr(ad(0, 0), 16'h0002);
    wr(ad(0, 1), 16'h0003);
    wr(ad(0, 2), 16'h0000);
    n = 0;
    raw_pwm[0] <= 1'b1;
    repeat (20)
    begin
      cyc(1);
      if (hi[0] === 1'b0 && lo[0] === 1'b0) n++;
    end
    chk({15'b0, n == 3 && hi[0] === 1'b1}, 16'h0001);
    n = 0;
    raw_pwm[0] <= 1'b0;
    repeat (20)
    begin
      cyc(1);
      if (hi[0] === 1'b0 && lo[0] === 1'b0) n++;
    end
    chk({15'b0, n == 4 && lo[0] === 1'b1}, 16'h0001);
    // Without PWM clock pulses the dead time never runs out
    raw_pwm[0] <= 1'b1;
    pwm_tick <= 1'b0;
    cyc(10);
    chk({14'b0, hi[0], lo[0]}, 16'h0000);
    pwm_tick <= 1'b1;
    cyc(10);
    chk({14'b0, hi[0], lo[0]}, 16'h0002);
    raw_pwm[0] <= 1'b0;
    cyc(10);
    chk({14'b0, hi[0], lo[0]}, 16'h0001);
    $display("dead time done");
  endtask

  task automatic t_blank;
    int n;
    int m;
    int k;
    wr(ad(0, 3), 16'h0005);
    wr(ad(0, 2), 16'h8800);
    fault_in[0] <= 1'b1;
    clim_in[0] <= 1'b1;
    cyc(6);
    chk({14'b0, f_out[0], c_out[0]}, 16'h0003);
    n = 0;
    m = 0;
    k = 0;
    raw_pwm[0] <= 1'b1;
    repeat (24)
    begin
      cyc(1);
      if (blank[0] === 1'b1) n++;
      if (f_out[0] === 1'b0) m++;
      if (c_out[0] === 1'b0) k++;
    end
    chk(16'(n), 16'h0005);
    chk({15'b0, m == 5 && f_out[0] === 1'b1}, 16'h0001);
    chk(16'(k), 16'h0000);
    n = 0;
    raw_pwm[0] <= 1'b0;
    repeat (20)
    begin
      cyc(1);
      if (blank[0] === 1'b1) n++;
    end
    chk(16'(n), 16'h0000);
    wr(ad(0, 2), 16'h0020);
    sblank[0] <= 1'b1;
    cyc(8);
    chk({14'b0, f_out[0], c_out[0]}, 16'h0000);
    sblank[0] <= 1'b0;
    cyc(8);
    chk({14'b0, f_out[0], c_out[0]}, 16'h0003);
    $display("blanking done");
  endtask

  // One raw PWM change on generator 1 (one output off, then the other on), counting blanked and masked cycles
  task automatic edge_case(input reg_word_t c, input logic lvl, input int eb, input int ef, input int ec);
    int n;
    int m;
    int k;
    wr(ad(1, 2), c);
    n = 0;
    m = 0;
    k = 0;
    raw_pwm[1] <= lvl;
    repeat (16)
    begin
      cyc(1);
      if (blank[1] === 1'b1) n++;
      if (f_out[1] === 1'b0) m++;
      if (c_out[1] === 1'b0) k++;
    end
    chk(16'(n), 16'(eb));
    chk(16'(m), 16'(ef));
    chk(16'(k), 16'(ec));
  endtask

  // One state blanking setting on generator 1, both masked inputs judged
  task automatic st_case(input reg_word_t c, input logic e);
    wr(ad(1, 2), c);
    cyc(4);
    chk({14'b0, f_out[1], c_out[1]}, {14'b0, e, e});
  endtask

  task automatic t_edges;
    wr(ad(1, 2), 16'h0000);
    wr(ad(1, 0), 16'h0001);
    wr(ad(1, 1), 16'h0001);
    wr(ad(1, 3), 16'h0004);
    fault_in[1] <= 1'b1;
    clim_in[1] <= 1'b1;
    cyc(6);
    edge_case(16'h1400, 1'b1, 4, 0, 4);
    edge_case(16'h4400, 1'b0, 4, 0, 4);
    edge_case(16'h2800, 1'b1, 0, 0, 0);
    edge_case(16'h2800, 1'b0, 4, 4, 0);
    st_case(16'h0008, 1'b1);
    st_case(16'h0004, 1'b0);
    st_case(16'h0002, 1'b0);
    st_case(16'h0001, 1'b1);
    st_case(16'h0010, 1'b0);
    $display("edge triggers done");
  endtask

  // Reset in mid-run returns registers to their reset values
  task automatic t_rerst;
    cyc(1);
    nrst <= 1'b0;
    cyc(3);
    nrst <= 1'b1;
    rd(ad(0, 0), 16'h0000);
    rd(ad(1, 2), 16'h0000);
    rd(ad(1, 3), 16'h0008);
    chk({14'b0, f_out[1], c_out[1]}, 16'h0003);
    $display("mid-run reset done");
  endtask

  task automatic finish_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Watchdog cuts a hang short
  initial
  begin
    #100us;
    failures++;
    finish_test;
  end

  // Main sequence
  initial
  begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {raw_pwm, sblank, fault_in, clim_in} = '0;
    pwm_tick = 1'b1;
    failures = 0;
    n_compared = 0;
    cyc(10);
    nrst <= 1'b1;
    t_reset;
    t_regs;
    t_dt;
    t_blank;
    t_edges;
    t_rerst;
    finish_test;
  end
endmodule // pwm_dt_blank_cfg_bench

// [pwm_dt_blank_cfg_checker.sv]
// Port assertions for the dead-time and blanking block
module pwm_dt_blank_cfg_checker
  import pwm_dt_pkg::*;
#(
  parameter int N = 5
)
(
  input wire logic                  sys_clk,
  input wire logic                  nrst,
  input wire pwm_dt_pkg::reg_addr_t reg_addr,
  input wire pwm_dt_pkg::reg_word_t reg_wdata,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire pwm_dt_pkg::reg_word_t reg_rdata,
  input wire logic                  pwm_tick,
  input wire logic [N-1:0]          raw_pwm,
  input wire logic [N-1:0]          state_blank_sig,
  input wire logic [N-1:0]          fault_in,
  input wire logic [N-1:0]          clim_in,
  input wire logic [N-1:0]          pwm_high_output,
  input wire logic [N-1:0]          pwm_low_output,
  input wire logic [N-1:0]          fault_out,
  input wire logic [N-1:0]          clim_out,
  input wire logic [N-1:0]          blank_active
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // Read data bus and register field checks
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read");
  a_dt_top_zero: assert property ($past(reg_rd) && !$past(reg_addr[1]) |-> reg_rdata[15:14] == 2'b00)
    else $error("dead time upper bits not zero");
  a_ctrl_gap_zero: assert property ($past(reg_rd) && $past(reg_addr[1:0]) == 2'b10 |-> reg_rdata[9:6] == 4'h0)
    else $error("blanking control gap not zero");
  a_unmapped_zero: assert property (reg_rd && reg_addr >= 8'h14 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");

  // Complementary outputs never overlap and turn on only after the other is off
  a_outs_exclusive: assert property ((pwm_high_output & pwm_low_output) == '0)
    else $error("high and low outputs both on");
  a_high_waits_low: assert property ((pwm_high_output & ~$past(pwm_high_output) & $past(pwm_low_output)) == '0)
    else $error("high turned on while low was on");
  a_low_waits_high: assert property ((pwm_low_output & ~$past(pwm_low_output) & $past(pwm_high_output)) == '0)
    else $error("low turned on while high was on");

  // Blanking counter only starts one cycle after an output edge
  a_blank_has_edge: assert property ((blank_active & ~$past(blank_active)
    & ~($past(pwm_high_output) ^ $past(pwm_high_output, 2))
    & ~($past(pwm_low_output) ^ $past(pwm_low_output, 2))) == '0)
    else $error("blanking started without an output edge");

  // Masked outputs only rise with a cause three cycles earlier
  a_fault_has_cause: assert property ((fault_out & ~$past(fault_in, 3)) == '0)
    else $error("fault output without fault input");
  a_clim_has_cause: assert property ((clim_out & ~$past(clim_in, 3)) == '0)
    else $error("limit output without limit input");
endmodule // pwm_dt_blank_cfg_checker

bind pwm_dt_blank_cfg pwm_dt_blank_cfg_checker #(.N(N)) i_chk (.sys_clk(sys_clk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pwm_tick(pwm_tick), .raw_pwm(raw_pwm), .state_blank_sig(state_blank_sig), .fault_in(fault_in),
  .clim_in(clim_in), .pwm_high_output(pwm_high_output), .pwm_low_output(pwm_low_output),
  .fault_out(fault_out), .clim_out(clim_out), .blank_active(blank_active));

// [pwm_dt_params.svh]
// Register offsets, field positions, reset values and widths for the dead-time and blanking block
`ifndef PWM_DT_PARAMS_SVH
`define PWM_DT_PARAMS_SVH

`define PWM_GEN_COUNT       5
`define REG_ADDR_W          8
`define REG_STRIDE          8'h04
`define OFS_DEAD_TIME       8'h00
`define OFS_ALT_DEAD_TIME   8'h01
`define OFS_BLANK_CTRL      8'h02
`define OFS_BLANK_COUNT     8'h03
`define DT_W                14
`define DT_MASK             16'h3FFF
`define BLANK_CTRL_MASK     16'hFC3F
`define REG_RESET           16'h0000
`define BIT_HIGH_RISE       15
`define BIT_HIGH_FALL       14
`define BIT_LOW_RISE        13
`define BIT_LOW_FALL        12
`define BIT_FAULT_BLANK     11
`define BIT_CLIM_BLANK      10
`define BIT_SIG_HIGH        5
`define BIT_SIG_LOW         4
`define BIT_HIGH_OUT_HIGH   3
`define BIT_HIGH_OUT_LOW    2
`define BIT_LOW_OUT_HIGH    1
`define BIT_LOW_OUT_LOW     0
`define BLANK_LEN_RESET     16'h0008

`endif

// [pwm_dt_pkg.sv]
// Types shared by the dead-time and blanking block
package pwm_dt_pkg;
  typedef logic [15:0] reg_word_t;
  typedef logic [7:0]  reg_addr_t;

  typedef enum logic [1:0]
  {
    DT_BOTH_OFF  = 2'b00,
    DT_HIGH_ON   = 2'b01,
    DT_LOW_ON    = 2'b10
  } dt_state_t;
endpackage
